// [design/hse_top.sv]
/*
  Hypervisor system-register interface enable and Group 0 acknowledge.
  Assumes the core presents one coprocessor access per cycle, context and
  pending-interrupt inputs from the same clock, and takes one-cycle answers.
*/
`timescale 1ns/1ps


module hse_top
  import hse_pkg::*;
#(
  parameter bit IRQ_BYPASS_SUPPORTED = 1'b1,
  parameter bit FIQ_BYPASS_SUPPORTED = 1'b1,
  parameter bit SYSREG_ONLY = 1'b0,
  parameter bit TRAP_EN_RAO = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Access from the core
  input wire hse_req_s req,
  output hse_rsp_s rsp,
  // Context from the surrounding interface
  input wire hse_ctx_s ctx,
  input wire hse_pend_s pend,
  // Activation towards the priority logic
  output logic act_valid,
  output logic [23:0] act_id,
  // Write-through to the monitor bypass copies
  output logic mon_bypass_wr,
  output logic mon_irq_bypass_wdata,
  output logic mon_fiq_bypass_wdata,
  // Effective controls for the other registers
  output logic hyp_sysreg_path_en,
  output logic kernel_enable_trap_hyp
);

  typedef struct packed {
    hse_rsp_s rsp;
    logic trap_en;
    logic irq_dis;
    logic fiq_dis;
    logic sel;
    logic act_valid;
    logic [23:0] act_id;
    logic mon_wr;
    logic mon_irq_dis;
    logic mon_fiq_dis;
    logic path_en;
    logic kern_trap;
  } hse_state_s;

  hse_state_s state_q;
  hse_state_s state_d;
  logic sel_hsre;
  logic sel_iar0;
  hse_result_e result;
  logic [23:0] ack_id;
  logic ack_real;
  logic [31:0] hsre_rd;
  logic sel_eff;
  logic trap_en_eff;

  // Match of an access against one register encoding
  function automatic logic enc_match(input hse_req_s r,
                                     input logic [2:0] o1,
                                     input logic [2:0] o2,
                                     input logic [3:0] n,
                                     input logic [3:0] m);
    enc_match = r.valid && r.coproc == `HSE_CP_NUM && r.opc1 == o1 &&
                r.opc2 == o2 && r.crn == n && r.crm == m;
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  assign sel_hsre = enc_match(req, `HSE_HSRE_OPC1, `HSE_HSRE_OPC2,
                              `HSE_HSRE_CRN, `HSE_HSRE_CRM);
  assign sel_iar0 = enc_match(req, `HSE_IAR0_OPC1, `HSE_IAR0_OPC2,
                              `HSE_IAR0_CRN, `HSE_IAR0_CRM);

  hse_access_check u_check (
    .sel_hsre(sel_hsre),
    .sel_iar0(sel_iar0),
    .write(req.write),
    .level(req.level),
    .ctx(ctx),
    .hyp_select(sel_eff),
    .result(result)
  );

  hse_ack_select u_ack (
    .pend(pend),
    .ack_id(ack_id),
    .ack_real(ack_real)
  );

  // ****************************************
  // Visible values of the enable register
  // ****************************************
  // Select: forced one in register-only builds, zero under monitor select 0
  always_comb begin
    if (SYSREG_ONLY) begin
      sel_eff = 1'b1;
    end else if (ctx.monitor_impl && !ctx.mon_interface_select) begin
      sel_eff = 1'b0;
    end else begin
      sel_eff = state_q.sel;
    end
    // Trap enable acts as 1 whenever select is 0, but reads as stored
    trap_en_eff = state_q.trap_en || !sel_eff;
    hsre_rd = 32'h0000_0000;
    hsre_rd[`HSE_BIT_SELECT] = sel_eff;
    hsre_rd[`HSE_BIT_ENABLE] = (SYSREG_ONLY && TRAP_EN_RAO) ||
                               state_q.trap_en;
    if (!IRQ_BYPASS_SUPPORTED) begin
      hsre_rd[`HSE_BIT_IRQ_BYP_DIS] = 1'b1;
    end else if (ctx.monitor_impl) begin
      hsre_rd[`HSE_BIT_IRQ_BYP_DIS] = ctx.mon_irq_bypass_disable;
    end else begin
      hsre_rd[`HSE_BIT_IRQ_BYP_DIS] = state_q.irq_dis;
    end
    if (!FIQ_BYPASS_SUPPORTED) begin
      hsre_rd[`HSE_BIT_FIQ_BYP_DIS] = 1'b1;
    end else if (ctx.monitor_impl) begin
      hsre_rd[`HSE_BIT_FIQ_BYP_DIS] = ctx.mon_fiq_bypass_disable;
    end else begin
      hsre_rd[`HSE_BIT_FIQ_BYP_DIS] = state_q.fiq_dis;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  // Answer and activation share one edge, so the core never sees the
  // answer before activation has reached signalling
  always_comb begin
    state_d = state_q;
    state_d.rsp.valid = req.valid;
    state_d.rsp.result = req.valid ? result : hse_res_nomatch;
    state_d.rsp.rdata = 32'h0000_0000;
    state_d.act_valid = 1'b0;
    state_d.mon_wr = 1'b0;
    if (result == hse_res_ok && sel_hsre && !req.write) begin
      state_d.rsp.rdata = hsre_rd;
    end
    if (result == hse_res_ok && sel_iar0) begin
      state_d.rsp.rdata = {8'h00, ack_id};
      state_d.act_valid = ack_real;
      state_d.act_id = ack_id;
    end
    if (result == hse_res_ok && sel_hsre && req.write) begin
      // Writes to bits 31 to 4 are dropped
      if (!(SYSREG_ONLY && TRAP_EN_RAO)) begin
        state_d.trap_en = req.wdata[`HSE_BIT_ENABLE];
      end
      if (!SYSREG_ONLY &&
          !(ctx.monitor_impl && !ctx.mon_interface_select)) begin
        state_d.sel = req.wdata[`HSE_BIT_SELECT];
      end
      if (ctx.monitor_impl) begin
        // Alias: pass through only when security is disabled
        state_d.mon_wr = ctx.distributor_security_disable;
        state_d.mon_irq_dis = IRQ_BYPASS_SUPPORTED ?
                              req.wdata[`HSE_BIT_IRQ_BYP_DIS] :
                              ctx.mon_irq_bypass_disable;
        state_d.mon_fiq_dis = FIQ_BYPASS_SUPPORTED ?
                              req.wdata[`HSE_BIT_FIQ_BYP_DIS] :
                              ctx.mon_fiq_bypass_disable;
      end else begin
        if (IRQ_BYPASS_SUPPORTED) begin
          state_d.irq_dis = req.wdata[`HSE_BIT_IRQ_BYP_DIS];
        end
        if (FIQ_BYPASS_SUPPORTED) begin
          state_d.fiq_dis = req.wdata[`HSE_BIT_FIQ_BYP_DIS];
        end
      end
    end
    // Published controls lag the stored bits by one edge
    state_d.path_en = sel_eff;
    state_d.kern_trap = ctx.nonsecure_state_flag && !trap_en_eff;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= '0;
      state_q.rsp.result <= hse_res_nomatch;
      state_q.trap_en <= `HSE_RST_ENABLE;
      state_q.irq_dis <= `HSE_RST_IRQ_BYP_DIS;
      state_q.fiq_dis <= `HSE_RST_FIQ_BYP_DIS;
      state_q.sel <= `HSE_RST_SELECT;
    end else begin
      state_q <= state_d;
    end
  end

  assign rsp = state_q.rsp;
  assign act_valid = state_q.act_valid;
  assign act_id = state_q.act_id;
  assign mon_bypass_wr = state_q.mon_wr;
  assign mon_irq_bypass_wdata = state_q.mon_irq_dis;
  assign mon_fiq_bypass_wdata = state_q.mon_fiq_dis;
  assign hyp_sysreg_path_en = state_q.path_en;
  assign kernel_enable_trap_hyp = state_q.kern_trap;

  // ****************************************
  // Checks
  // ****************************************
  // Each check except AST_ACT_WITH_ANSWER looks one edge past its trigger, where the answer or the published control stands
  AST_ACT_WITH_ANSWER: assert property (
    @(posedge clk_sys) disable iff (srst)
    act_valid |-> rsp.valid && rsp.result == hse_res_ok &&
    rsp.rdata[23:0] == act_id)
    else $error("activation without matching acknowledge answer");

  AST_ANSWER_NEXT: assert property (
    @(posedge clk_sys) disable iff (srst)
    req.valid |=> rsp.valid)
    else $error("access left without an answer");

  AST_IAR0_TOP_ZERO: assert property (
    @(posedge clk_sys) disable iff (srst)
    sel_iar0 && !req.write ##1 rsp.valid |-> rsp.rdata[31:24] == 8'h00)
    else $error("acknowledge top byte not zero");

  AST_HSRE_RSV_ZERO: assert property (
    @(posedge clk_sys) disable iff (srst)
    sel_hsre |=> rsp.rdata[31:4] == 28'h0)
    else $error("enable register reserved bits not zero");

  AST_SPECIAL_ID: assert property (
    @(posedge clk_sys) disable iff (srst)
    sel_iar0 && result == hse_res_ok && !pend.priority_ok |=>
    rsp.rdata[23:0] == `HSE_ID_SPURIOUS && !act_valid)
    else $error("unsignalable interrupt acknowledged");

  AST_TRAP_EN_FORCED: assert property (
    @(posedge clk_sys) disable iff (srst)
    !sel_eff && ctx.nonsecure_state_flag |=> !kernel_enable_trap_hyp)
    else $error("trap enable not treated as one while select is 0");

  // Watches the published control, not the combinational select
  AST_SEL_RAZ: assert property (
    @(posedge clk_sys) disable iff (srst)
    ctx.monitor_impl && !ctx.mon_interface_select && !SYSREG_ONLY
    |=> !hyp_sysreg_path_en)
    else $error("select readable while monitor select is 0");

  AST_KERNEL_HSRE_UNDEF: assert property (
    @(posedge clk_sys) disable iff (srst)
    sel_hsre && req.level inside {hse_lvl_user, hse_lvl_kernel} |=>
    rsp.valid && rsp.result == hse_res_undef)
    else $error("low-level enable register access not undefined");

  AST_TALL0_TRAP: assert property (
    @(posedge clk_sys) disable iff (srst)
    sel_iar0 && !req.write && req.level == hse_lvl_kernel &&
    ctx.kernel_interface_select && ctx.nonsecure_state_flag &&
    !ctx.hyp_general_trap && ctx.hyp_group0_trap_all
    |=> rsp.result == hse_res_trap_hyp && !act_valid)
    else $error("trap-all did not trap kernel acknowledge");

  AST_ALIAS_RO: assert property (
    @(posedge clk_sys) disable iff (srst)
    sel_hsre && req.write && !ctx.distributor_security_disable
    |=> !mon_bypass_wr)
    else $error("bypass alias written while read-only");

  AST_ALIAS_WRITE: assert property (
    @(posedge clk_sys) disable iff (srst)
    sel_hsre && req.write && result == hse_res_ok && ctx.monitor_impl &&
    ctx.distributor_security_disable |=> mon_bypass_wr)
    else $error("bypass alias not written through");

  AST_HYP_SEL_UNDEF: assert property (
    @(posedge clk_sys) disable iff (srst)
    sel_iar0 && req.level == hse_lvl_hyp && !sel_eff
    |=> rsp.result == hse_res_undef && !act_valid)
    else $error("hypervisor acknowledge allowed with select 0");

endmodule // hse_top

// [design/hse_cfg.svh]
/*
  Constants for the hypervisor interface-enable and Group 0 acknowledge
  block: instruction encodings, bit positions, reset values, special IDs.
  Assumes inclusion by bare name from the package and the bench files.
*/
`ifndef HSE_CFG_SVH
`define HSE_CFG_SVH

// ****************************************
// Instruction encodings
// ****************************************
`define HSE_CP_NUM 4'hf
`define HSE_HSRE_OPC1 3'h4
`define HSE_HSRE_OPC2 3'h5
`define HSE_HSRE_CRN 4'hc
`define HSE_HSRE_CRM 4'h9
`define HSE_IAR0_OPC1 3'h0
`define HSE_IAR0_OPC2 3'h0
`define HSE_IAR0_CRN 4'hc
`define HSE_IAR0_CRM 4'h8

// ****************************************
// Enable register layout and reset values
// ****************************************
`define HSE_BIT_ENABLE 3
`define HSE_BIT_IRQ_BYP_DIS 2
`define HSE_BIT_FIQ_BYP_DIS 1
`define HSE_BIT_SELECT 0
`define HSE_RST_ENABLE 1'b0
`define HSE_RST_IRQ_BYP_DIS 1'b0
`define HSE_RST_FIQ_BYP_DIS 1'b0
`define HSE_RST_SELECT 1'b0

// ****************************************
// Identifier field
// ****************************************
`define HSE_ID_BITS 24
`define HSE_ID_SPURIOUS 24'h0003ff
`define HSE_ID_NS_GROUP1 24'h0003fd
`define HSE_ID_S_GROUP1 24'h0003fc

`endif

// [design/hse_pkg.sv]
/*
  Types shared by the interface-enable block: levels, access results and
  the carriers for requests, context, pending interrupt and response.
  Assumes hse_cfg.svh is on the include path.
*/
`include "hse_cfg.svh"

package hse_pkg;

  // Privilege level of the issuing access
  typedef enum logic [1:0] {
    hse_lvl_user,
    hse_lvl_kernel,
    hse_lvl_hyp,
    hse_lvl_mon
  } hse_level_e;

  // Outcome of an access
  typedef enum logic [2:0] {
    hse_res_ok,
    hse_res_undef,
    hse_res_trap_hyp,
    hse_res_trap_mon,
    hse_res_virtual,
    hse_res_nomatch
  } hse_result_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] coproc;
    logic [2:0] opc1;
    logic [2:0] opc2;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [31:0] wdata;
    hse_level_e level;
  } hse_req_s;

  typedef struct packed {
    logic nonsecure_state_flag;
    logic hyp_general_trap;
    logic fiq_route_to_hyp;
    logic fiq_route_to_monitor;
    logic hyp_group0_trap_all;
    logic distributor_security_disable;
    logic monitor_impl;
    logic monitor_is_64;
    logic mon_interface_select;
    logic mon_lower_enable;
    logic mon_irq_bypass_disable;
    logic mon_fiq_bypass_disable;
    logic kernel_interface_select;
  } hse_ctx_s;

  typedef struct packed {
    logic valid;
    logic priority_ok;
    logic ackable;
    logic ns_group1;
    logic [23:0] id;
  } hse_pend_s;

  typedef struct packed {
    logic valid;
    hse_result_e result;
    logic [31:0] rdata;
  } hse_rsp_s;

endpackage

// [design/hse_access_check.sv]
/*
  Combinational access decision for the two registers: undefined, trap,
  redirect to the virtual register, or plain access.
  Assumes a decoded register select and level-context from the same clock.
*/
`timescale 1ns/1ps

module hse_access_check
  import hse_pkg::*;
(
  // Decoded access
  input wire logic sel_hsre,
  input wire logic sel_iar0,
  input wire logic write,
  input wire hse_level_e level,
  // Context
  input wire hse_ctx_s ctx,
  input wire logic hyp_select,
  // Decision
  output hse_result_e result
);

  logic ns;
  logic mon64_fiq;

  // ****************************************
  // Decision tree, highest priority first
  // ****************************************
  always_comb begin
    ns = ctx.nonsecure_state_flag;
    mon64_fiq = ctx.monitor_impl && ctx.monitor_is_64 &&
                ctx.fiq_route_to_monitor;
    result = hse_res_nomatch;
    if (sel_hsre) begin
      result = hse_res_ok;
      // Only hypervisor and monitor levels, non-secure only
      if (!ns || level == hse_lvl_user || level == hse_lvl_kernel) begin
        result = hse_res_undef;
      end else if (level == hse_lvl_hyp && ctx.monitor_impl &&
                   !ctx.mon_lower_enable) begin
        result = ctx.monitor_is_64 ? hse_res_trap_mon
                                   : hse_res_undef;
      end
    end else if (sel_iar0) begin
      result = hse_res_ok;
      if (write || level == hse_lvl_user) begin
        result = hse_res_undef;
      end else if (level == hse_lvl_kernel) begin
        if (!ctx.kernel_interface_select) begin
          result = hse_res_undef;
        end else if (ns && ctx.hyp_general_trap) begin
          result = hse_res_undef;
        end else if (ns && ctx.hyp_group0_trap_all) begin
          result = hse_res_trap_hyp;
        end else if (mon64_fiq && !(ns && ctx.fiq_route_to_hyp)) begin
          result = hse_res_trap_mon;
        end else if (ns && ctx.fiq_route_to_hyp) begin
          result = hse_res_virtual;
        end
      end else if (level == hse_lvl_hyp) begin
        if (!hyp_select) begin
          result = hse_res_undef;
        end else if (mon64_fiq) begin
          result = hse_res_trap_mon;
        end
      end else if (!ctx.mon_interface_select) begin
        result = hse_res_undef;
      end
    end
  end

endmodule // hse_access_check

// [design/hse_ack_select.sv]
/*
  Combinational choice of the identifier an acknowledge read returns:
  the pending one, or a special identifier giving the reason.
  Assumes the pending interrupt comes from priority logic on the same clock.
*/
`timescale 1ns/1ps

module hse_ack_select
  import hse_pkg::*;
(
  // Pending interrupt
  input wire hse_pend_s pend,
  // Chosen identifier and whether it is a real interrupt
  output logic [23:0] ack_id,
  output logic ack_real
);

  // Narrow builds clear the top byte of the field
  function automatic logic [23:0] trim_id(input logic [23:0] id);
    trim_id = id;
    if (`HSE_ID_BITS == 16) begin
      trim_id[23:16] = 8'h00;
    end
  endfunction

  // ****************************************
  // Selection
  // ****************************************
  always_comb begin
    ack_real = 1'b0;
    if (!pend.valid || !pend.priority_ok) begin
      ack_id = `HSE_ID_SPURIOUS;
    end else if (!pend.ackable) begin
      ack_id = pend.ns_group1 ? `HSE_ID_NS_GROUP1
                              : `HSE_ID_S_GROUP1;
    end else begin
      ack_id = trim_id(pend.id);
      ack_real = 1'b1;
    end
  end

endmodule // hse_ack_select

// [tb/hse_core_model.sv]
/*
  Core-side model: issues one coprocessor access at a time and takes the
  registered answer. Assumes the answer comes one edge after the request.
*/
`timescale 1ns/1ps
`include "hse_cfg.svh"

module hse_core_model
  import hse_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Access bus
  output hse_req_s req,
  input wire hse_rsp_s rsp
);
  logic sel_set_q; // Select bit once written to one

  initial begin
    req = '0;
    sel_set_q = 1'b0;
  end

  // One access: launch after an edge, hold until taken, then release
  task automatic do_access(input logic wr, input logic [2:0] o1,
      input logic [2:0] o2, input logic [3:0] n, input logic [3:0] m,
      input logic [31:0] wd, input hse_level_e lv, output hse_rsp_s got);
    hse_req_s r;
    hse_req_s idle;
    r = '0;
    r.valid = 1'b1;
    r.write = wr;
    r.coproc = `HSE_CP_NUM;
    r.opc1 = o1;
    r.opc2 = o2;
    r.crn = n;
    r.crm = m;
    r.wdata = wd;
    r.level = lv;
    // Software never takes the select bit back to zero
    if (wr && m == `HSE_HSRE_CRM && o2 == `HSE_HSRE_OPC2) begin
      if (sel_set_q) begin
        r.wdata[`HSE_BIT_SELECT] = 1'b1;
      end
      sel_set_q = sel_set_q | wd[`HSE_BIT_SELECT];
    end
    @(posedge clk_sys);
    req <= r;
    @(posedge clk_sys);
    idle = ~r;
    idle.valid = 1'b0;
    req <= idle; // Released lines show junk, not the last value
    #1;
    got = rsp;
  endtask
endmodule // hse_core_model

// [tb/cpu_iface_hyp_enable_ack0_tb.sv]
/*
  Self-checking bench for the enable register and Group 0 acknowledge.
  Assumes hse_top with default parameters and the core model beside it.
*/
`timescale 1ns/1ps
`include "hse_cfg.svh"

module cpu_iface_hyp_enable_ack0_tb
  import hse_pkg::*;
;
  logic clk_sys;
  logic srst;
  hse_req_s req;
  hse_rsp_s rsp;
  hse_ctx_s ctx;
  hse_pend_s pend;
  logic act_valid;
  logic [23:0] act_id;
  logic mon_bypass_wr;
  logic mon_irq_bypass_wdata;
  logic mon_fiq_bypass_wdata;
  logic hyp_sysreg_path_en;
  logic kernel_enable_trap_hyp;
  int n_mismatch;
  int tests_run;
  hse_rsp_s got;
  hse_ctx_s c;
  hse_pend_s p;

  hse_top dut_u (.clk_sys(clk_sys), .srst(srst), .req(req), .rsp(rsp),
    .ctx(ctx), .pend(pend), .act_valid(act_valid), .act_id(act_id),
    .mon_bypass_wr(mon_bypass_wr),
    .mon_irq_bypass_wdata(mon_irq_bypass_wdata),
    .mon_fiq_bypass_wdata(mon_fiq_bypass_wdata),
    .hyp_sysreg_path_en(hyp_sysreg_path_en),
    .kernel_enable_trap_hyp(kernel_enable_trap_hyp));

  hse_core_model core_u (.clk_sys(clk_sys), .req(req), .rsp(rsp));

  // ****************************************
  // Clock, verdict and watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // About 30 accesses of three cycles each; ample margin
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic put(input hse_ctx_s cv, input hse_pend_s pv);
    @(posedge clk_sys);
    ctx <= cv;
    pend <= pv;
  endtask

  task automatic hsre(input logic wr, input logic [31:0] wd,
      input hse_level_e lv, input hse_result_e er, input logic [31:0] ed);
    put(c, p);
    core_u.do_access(wr, `HSE_HSRE_OPC1, `HSE_HSRE_OPC2, `HSE_HSRE_CRN,
      `HSE_HSRE_CRM, wd, lv, got);
    chk("rsp_valid", 32'(got.valid), 32'h1);
    chk("result", 32'(got.result), 32'(er));
    chk("rdata", got.rdata, ed);
  endtask

  // Acknowledge read; activation expected only for a real identifier
  task automatic ack(input hse_level_e lv, input hse_result_e er,
      input logic [31:0] ed);
    logic real_id;
    real_id = (er == hse_res_ok) && !(ed[23:0] inside {`HSE_ID_SPURIOUS,
      `HSE_ID_NS_GROUP1, `HSE_ID_S_GROUP1});
    put(c, p);
    core_u.do_access(1'b0, `HSE_IAR0_OPC1, `HSE_IAR0_OPC2, `HSE_IAR0_CRN,
      `HSE_IAR0_CRM, 32'h0, lv, got);
    chk("ack_result", 32'(got.result), 32'(er));
    chk("ack_rdata", got.rdata, ed);
    chk("act_valid", 32'(act_valid), 32'(real_id));
    if (real_id) begin
      chk("act_id", 32'(act_id), ed);
    end
  endtask

  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    srst = 1'b1;
    ctx = '0;
    pend = '0;
    n_mismatch = 0;
    tests_run = 0;
    c = '0;
    c.nonsecure_state_flag = 1'b1;
    p = '0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    // Reset values, then select still zero
    hsre(1'b0, 32'h0, hse_lvl_hyp, hse_res_ok, 32'h0);
    settle();
    chk("path_en", 32'(hyp_sysreg_path_en), 32'h0);
    chk("kern_trap", 32'(kernel_enable_trap_hyp), 32'h0);
    ack(hse_lvl_kernel, hse_res_undef, 32'h0);
    ack(hse_lvl_hyp, hse_res_undef, 32'h0);
    // Reserved bits drop, select and trap enable take effect
    hsre(1'b1, 32'hffffffff, hse_lvl_hyp, hse_res_ok, 32'h0);
    hsre(1'b0, 32'h0, hse_lvl_hyp, hse_res_ok, 32'hf);
    settle();
    chk("path_en", 32'(hyp_sysreg_path_en), 32'h1);
    chk("kern_trap", 32'(kernel_enable_trap_hyp), 32'h0);
    hsre(1'b1, 32'h1, hse_lvl_hyp, hse_res_ok, 32'h0);
    hsre(1'b0, 32'h0, hse_lvl_hyp, hse_res_ok, 32'h1);
    settle();
    chk("kern_trap", 32'(kernel_enable_trap_hyp), 32'h1);
    hsre(1'b1, 32'h0, hse_lvl_mon, hse_res_ok, 32'h0);
    hsre(1'b0, 32'h0, hse_lvl_mon, hse_res_ok, 32'h1);
    // Wrong level, wrong state, wrong encoding, write to acknowledge
    hsre(1'b0, 32'h0, hse_lvl_kernel, hse_res_undef, 32'h0);
    hsre(1'b0, 32'h0, hse_lvl_user, hse_res_undef, 32'h0);
    c.nonsecure_state_flag = 1'b0;
    hsre(1'b0, 32'h0, hse_lvl_hyp, hse_res_undef, 32'h0);
    c.nonsecure_state_flag = 1'b1;
    core_u.do_access(1'b0, `HSE_HSRE_OPC1, `HSE_HSRE_OPC2, `HSE_HSRE_CRN,
      4'ha, 32'h0, hse_lvl_hyp, got);
    chk("bad_crm", 32'(got.result), 32'(hse_res_nomatch));
    core_u.do_access(1'b1, `HSE_IAR0_OPC1, `HSE_IAR0_OPC2, `HSE_IAR0_CRN,
      `HSE_IAR0_CRM, 32'h5, hse_lvl_hyp, got);
    chk("ack_write", 32'(got.result), 32'(hse_res_undef));
    // Acknowledge: real identifier, then each special identifier
    c.kernel_interface_select = 1'b1;
    p = '{valid: 1'b1, priority_ok: 1'b1, ackable: 1'b1, ns_group1: 1'b0,
      id: 24'habcdef};
    ack(hse_lvl_kernel, hse_res_ok, 32'h00abcdef);
    p.id = 24'h000123;
    ack(hse_lvl_hyp, hse_res_ok, 32'h00000123);
    p.ackable = 1'b0;
    ack(hse_lvl_kernel, hse_res_ok, 32'h3fc);
    p.ns_group1 = 1'b1;
    ack(hse_lvl_kernel, hse_res_ok, 32'h3fd);
    p.priority_ok = 1'b0;
    ack(hse_lvl_kernel, hse_res_ok, 32'h3ff);
    p = '0;
    ack(hse_lvl_kernel, hse_res_ok, 32'h3ff);
    // Trap and redirect paths
    c.hyp_group0_trap_all = 1'b1;
    ack(hse_lvl_kernel, hse_res_trap_hyp, 32'h0);
    c.hyp_group0_trap_all = 1'b0;
    c.fiq_route_to_hyp = 1'b1;
    ack(hse_lvl_kernel, hse_res_virtual, 32'h0);
    c.fiq_route_to_hyp = 1'b0;
    c.monitor_impl = 1'b1;
    c.monitor_is_64 = 1'b1;
    c.mon_interface_select = 1'b1;
    c.mon_lower_enable = 1'b1;
    c.fiq_route_to_monitor = 1'b1;
    ack(hse_lvl_kernel, hse_res_trap_mon, 32'h0);
    ack(hse_lvl_hyp, hse_res_trap_mon, 32'h0);
    c.fiq_route_to_monitor = 1'b0;
    // Monitor present: lower enable, bypass aliases, select masking
    c.mon_lower_enable = 1'b0;
    hsre(1'b0, 32'h0, hse_lvl_hyp, hse_res_trap_mon, 32'h0);
    c.monitor_is_64 = 1'b0;
    hsre(1'b0, 32'h0, hse_lvl_hyp, hse_res_undef, 32'h0);
    c.mon_lower_enable = 1'b1;
    c.mon_irq_bypass_disable = 1'b1;
    hsre(1'b0, 32'h0, hse_lvl_hyp, hse_res_ok, 32'h5);
    c.distributor_security_disable = 1'b1;
    hsre(1'b1, 32'h3, hse_lvl_hyp, hse_res_ok, 32'h0);
    chk("mon_wr", 32'(mon_bypass_wr), 32'h1);
    chk("irq_wd", 32'(mon_irq_bypass_wdata), 32'h0);
    chk("fiq_wd", 32'(mon_fiq_bypass_wdata), 32'h1);
    c.distributor_security_disable = 1'b0;
    hsre(1'b1, 32'h7, hse_lvl_hyp, hse_res_ok, 32'h0);
    chk("mon_wr", 32'(mon_bypass_wr), 32'h0);
    c.mon_interface_select = 1'b0;
    hsre(1'b0, 32'h0, hse_lvl_hyp, hse_res_ok, 32'h4);
    // Reset in mid-run clears the stored bits again
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    c = '0;
    c.nonsecure_state_flag = 1'b1;
    hsre(1'b0, 32'h0, hse_lvl_hyp, hse_res_ok, 32'h0);
    settle();
    chk("path_en", 32'(hyp_sysreg_path_en), 32'h0);
    end_of_test();
  end
endmodule // cpu_iface_hyp_enable_ack0_tb
